// *** sar_adc_sequencer_tb.sv ***
// Self-checking bench: random scan settings over all trigger sources.
// Assumes the analog core model and the port checker beside the design.
`timescale 1ns/1ns
module sar_adc_sequencer_tb;
    logic clk_i = 1'b0, arst_n_i = 1'b0, tmr = 1'b0, ext_n = 1'b1;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [3:0] awaddr = '0, araddr = '0, div;
    logic [31:0] wdata = '0, rdata;
    logic [9:0] adc_res;
    logic awready, wready, bvalid, arready, rvalid, adc_clk, smp, cvt, irq;
    logic [1:0] bresp, rresp, src;
    logic [2:0] chan, ch_last, first, last, samp;
    logic [2:0] ch_q[$];
    int err_count = 0, checks = 0, s_n = 0, c_n = 0, exp_s, exp_c;
    bit mon_on = 0, cvt_q = 0, just, mode;
    logic [1:0] srcs[3] = '{sarseq_pkg::SRC_SOFT, sarseq_pkg::SRC_TIMER,
        sarseq_pkg::SRC_EXT};

    initial forever #5 clk_i = ~clk_i;

    sarseq_top i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'h3), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .timer_underflow_i(tmr),
        .ext_trigger_pin_n_i(ext_n), .adc_result_i(adc_res),
        .adc_clk_o(adc_clk), .adc_channel_o(chan), .adc_sample_o(smp),
        .adc_convert_o(cvt), .irq_o(irq));
    sarseq_core_model i_core (.clk_i(clk_i), .convert_i(cvt),
        .channel_i(chan), .result_o(adc_res));

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic timeout();
        err_count++;
        $display("timeout at %0t", $time);
        conclude();
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Write one register; each channel released once taken
    task automatic axi_wr(input logic [3:0] a, input logic [15:0] d);
        bit aw_t, w_t, b_t;
        logic [1:0] r;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_t = 0;
        for (int n = 0; n < 64 && !b_t; n++) begin
            @(negedge clk_i);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid;
            r = bresp;
            @(posedge clk_i);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (!b_t) timeout();
        check(r, sarseq_pkg::RESP_OKAY);
    endtask

    // Read one register
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        bit ar_t, r_t;
        logic [1:0] r;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_t = 0;
        for (int n = 0; n < 64 && !r_t; n++) begin
            @(negedge clk_i);
            ar_t = arvalid && arready;
            r_t = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk_i);
            if (ar_t) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (!r_t) timeout();
        check(r, sarseq_pkg::RESP_OKAY);
    endtask

    // Raise one start event of the given source
    task automatic fire(input logic [1:0] s, input bit en);
        case (s)
            sarseq_pkg::SRC_SOFT: axi_wr(sarseq_pkg::ADDR_CTL,
                {12'h000, en, en, 1'b1, en});
            sarseq_pkg::SRC_TIMER: begin
                @(posedge clk_i);
                tmr <= 1'b1;
                @(posedge clk_i);
                tmr <= 1'b0;
            end
            default: begin
                @(posedge clk_i);
                ext_n <= 1'b0;
                repeat (8) @(posedge clk_i);
                ext_n <= 1'b1;
            end
        endcase
    endtask

    task automatic idle_chk();
        repeat (16) @(negedge clk_i);
        check(smp, 1'b0);
    endtask

    function automatic logic [31:0] exp_res(input logic [2:0] c);
        logic [9:0] r;
        r = {c, 7'h35};
        return just ? {16'h0000, r, 6'h00} : {22'h00_0000, r};
    endfunction

    // Phase lengths and completed channels, sampled mid-cycle
    always @(negedge clk_i) begin
        if (mon_on && cvt && !cvt_q) begin
            check(s_n, exp_s);
            check(adc_clk, 1'b0);
        end
        if (mon_on && !cvt && cvt_q) begin
            check(c_n, exp_c);
            ch_q.push_back(ch_last);
        end
        s_n = smp ? s_n + 1 : 0;
        c_n = cvt ? c_n + 1 : 0;
        cvt_q = cvt;
        ch_last = chan;
    end

    task automatic run_scan();
        logic [31:0] d;
        logic [15:0] trig;
        logic [2:0] ch;
        int n, m;
        n = 32'(3'(last - first)) + 1;
        m = mode ? n + 1 : n;
        exp_s = (samp + 2) << (div + 1);
        exp_c = 11 << (div + 1);
        trig = {just, samp, 1'b0, src, mode, 1'b0, last, 1'b0, first};
        axi_wr(sarseq_pkg::ADDR_CTL, 16'h0020);
        axi_rd(sarseq_pkg::ADDR_CTL, d);
        check(d[7:0], 8'h00);
        axi_wr(sarseq_pkg::ADDR_TRIG, trig);
        axi_wr(sarseq_pkg::ADDR_CLK, {12'h000, div});
        axi_rd(sarseq_pkg::ADDR_TRIG, d);
        check(d, {16'h0000, trig});
        fire(src, 1'b0);
        idle_chk();
        axi_wr(sarseq_pkg::ADDR_CTL, 16'h000d);
        for (int s = 0; s < 4; s++)
            if (s != 2 && 2'(s) != src) fire(2'(s), 1'b1);
        idle_chk();
        ch_q.delete();
        mon_on = 1;
        fire(src, 1'b1);
        for (int k = 0; k < m; k++) begin
            for (int w = 0; w < 5000 && ch_q.size() == 0; w++)
                @(negedge clk_i);
            if (ch_q.size() == 0) timeout();
            ch = ch_q.pop_front();
            check(ch, 3'(first + k % n));
            if (k == 0) check(irq, 1'b1);
            if (k == 0 && n > 1) begin
                axi_rd(sarseq_pkg::ADDR_CTL, d);
                check({d[10:8], d[1]}, {3'(first + 1), 1'b1});
            end else begin
                axi_rd(sarseq_pkg::ADDR_RESULT, d);
                check(d, exp_res(ch));
            end
        end
        // Continuous scans are stopped by clearing the active bit
        if (mode) begin
            repeat (exp_s + 4) @(posedge clk_i);
            mon_on = 0;
            axi_wr(sarseq_pkg::ADDR_CTL, 16'h000d);
        end
        repeat (4) @(negedge clk_i);
        check({smp, cvt}, 2'b00);
        axi_rd(sarseq_pkg::ADDR_CTL, d);
        check({d[5], d[4], d[1]}, {n > 1, 2'b00});
        check(irq, n > 1);
        mon_on = 0;
    endtask

    // Reset, register defaults, then random scans over every source
    initial begin
        logic [31:0] d;
        void'($urandom(40687));
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        axi_rd(sarseq_pkg::ADDR_TRIG, d);
        check(d, 32'h0000_7000);
        axi_rd(sarseq_pkg::ADDR_CLK, d);
        check(d, 32'h0000_0000);
        for (int it = 0; it < 9; it++) begin
            src = srcs[it % 3];
            mode = (it % 4 == 3);
            first = (it == 0) ? 3'h6 : 3'($urandom_range(7));
            last = (it == 0) ? 3'h1 : 3'($urandom_range(7));
            samp = 3'($urandom_range(7));
            div = 4'($urandom_range(1));
            just = 1'($urandom_range(1));
            run_scan();
        end
        conclude();
    end
endmodule

bind sarseq_top sarseq_properties i_props (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
    .adc_channel_o(adc_channel_o), .adc_sample_o(adc_sample_o),
    .adc_convert_o(adc_convert_o), .irq_o(irq_o));

// *** sarseq_clk_if.sv ***
// Interface between the sequencer and its conversion clock divider.
// Assumes both ends run on the same peripheral clock.
`timescale 1ns/1ns
interface sarseq_clk_if;
    logic [3:0] div_sel;
    logic restart;
    logic tick;
    logic level;

    modport gen (input div_sel, input restart, output tick, output level);
    modport user (output div_sel, output restart, input tick, input level);
endinterface

// *** sarseq_clkdiv.sv ***
// Conversion clock divider: one tick per conversion clock period.
// Assumes div_sel is steady while the converter runs.
`timescale 1ns/1ns
module sarseq_clkdiv (
    input wire logic clk_i,
    input wire logic arst_n_i,
    sarseq_clk_if.gen cif
);
    logic [sarseq_pkg::DIV_CNT_W-1:0] cnt_q;
    logic [sarseq_pkg::DIV_CNT_W-1:0] cnt_d;
    logic [sarseq_pkg::DIV_CNT_W-1:0] limit;
    logic [3:0] sel;
    logic lvl_q;

    // Reserved code behaves as the slowest ratio; period is 2^(sel+1)
    assign sel = (cif.div_sel > sarseq_pkg::DIV_MAX) ?
                 sarseq_pkg::DIV_MAX : cif.div_sel;
    assign limit = sarseq_pkg::DIV_CNT_W'((32'h0000_0002 << sel) - 1);
    assign cif.tick = (cnt_q == limit) && !cif.restart;
    assign cnt_d = (cif.restart || cnt_q == limit) ?
                   '0 : cnt_q + 1'b1;
    assign cif.level = lvl_q;

    // Period counter, restarted at the start of each scan
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= '0;
            lvl_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            lvl_q <= cnt_d[sel];
        end
    end
endmodule

// *** sarseq_core_model.sv ***
// Behavioural analog core: result depends on the converted channel.
// Assumes convert and channel come straight from the sequencer.
`timescale 1ns/1ns
module sarseq_core_model (
    input wire logic clk_i,
    input wire logic convert_i,
    input wire logic [2:0] channel_i,
    output logic [9:0] result_o
);
    logic [9:0] noise_q = 10'h155;

    // Changing pattern outside conversion so stale data never matches
    always_ff @(posedge clk_i) begin
        noise_q <= noise_q + 10'h001;
    end
    assign result_o = convert_i ? {channel_i, 7'h35} : noise_q;
endmodule

// *** sarseq_pkg.sv ***
// Package for the SAR converter sequencer: register map, field layout,
// reset values, timing counts and the sequencer state type.
// Assumes a 16-bit register view carried on a 32-bit AXI4-Lite bus.
package sarseq_pkg;

    // Register indices; byte address is four times the index
    localparam int IDX_RESULT = 0;
    localparam int IDX_TRIG = 1;
    localparam int IDX_CTL = 2;
    localparam int IDX_CLK = 3;
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_RESULT = 4'(IDX_RESULT * 4);
    localparam logic [3:0] ADDR_TRIG = 4'(IDX_TRIG * 4);
    localparam logic [3:0] ADDR_CTL = 4'(IDX_CTL * 4);
    localparam logic [3:0] ADDR_CLK = 4'(IDX_CLK * 4);

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Trigger/channel register fields
    localparam int TRG_FIRST_LSB = 0;
    localparam int TRG_LAST_LSB = 4;
    localparam int TRG_MODE_BIT = 8;
    localparam int TRG_SRC_LSB = 9;
    localparam int TRG_SAMP_LSB = 12;
    localparam int TRG_JUST_BIT = 15;

    // Control/status register fields
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_ACT_BIT = 1;
    localparam int CTL_RIE_BIT = 2;
    localparam int CTL_OIE_BIT = 3;
    localparam int CTL_RDY_BIT = 4;
    localparam int CTL_OVR_BIT = 5;
    localparam int CTL_CHAN_LSB = 8;

    // Reset values
    localparam logic [2:0] CHAN_RST = 3'h0;
    localparam logic [1:0] SRC_RST = 2'h0;
    localparam logic [2:0] SAMP_RST = 3'h7;
    localparam logic [3:0] DIV_RST = 4'h0;

    // Trigger source codes
    localparam logic [1:0] SRC_SOFT = 2'h0;
    localparam logic [1:0] SRC_TIMER = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h3;

    // Divider codes and conversion timing, in conversion clock cycles
    localparam logic [3:0] DIV_MAX = 4'he;
    localparam int DIV_CNT_W = 15;
    localparam int SAMP_BASE = 2;
    localparam int CONV_CYCLES = 11;
    localparam logic [3:0] SAMP_LAST_OFS = 4'(SAMP_BASE - 1);
    localparam logic [3:0] CONV_LAST = 4'(CONV_CYCLES - 1);

    typedef enum logic [1:0] {
        SQ_IDLE,
        SQ_SAMPLE,
        SQ_CONVERT
    } sarseq_state_t;

endpackage

// *** sarseq_properties.sv ***
// Port-level checks for the sequencer top module.
// Assumes it is bound into sarseq_top and sees only its ports.
`timescale 1ns/1ns
module sarseq_properties (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [2:0] adc_channel_o,
    input wire logic adc_sample_o,
    input wire logic adc_convert_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    // Shortest sampling phase seen when a scan is not aborted; convert run is well under its 22 cycles
    sequence samp_run;
        adc_sample_o [*3];
    endsequence
    sequence conv_run;
        adc_convert_o [*5];
    endsequence

    // Phase ordering and length, channel hold and interrupt cause
    a_phase_excl: assert property (
        !(adc_sample_o && adc_convert_o))
        else $error("sample and convert overlap");
    a_conv_after_samp: assert property (
        $rose(adc_convert_o) |-> $past(adc_sample_o))
        else $error("convert started without sampling");
    a_samp_min_len: assert property (
        $rose(adc_sample_o) |=> samp_run)
        else $error("sampling phase too short");
    a_conv_min_len: assert property (
        $rose(adc_convert_o) |=> conv_run)
        else $error("convert phase too short");
    a_chan_steady: assert property (
        adc_convert_o |-> $stable(adc_channel_o))
        else $error("channel moved during convert");
    a_irq_cause: assert property (
        $rose(irq_o) |-> $past(adc_convert_o) || $rose(s_axi_bvalid_o))
        else $error("interrupt rose without cause");

    // Register bus handshakes
    a_read_answer: assert property (
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read not answered next cycle");
    a_rdata_hold: assert property (
        s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped before taken");
    a_aw_blocked: assert property (
        s_axi_bvalid_o |-> !s_axi_awready_o)
        else $error("write address taken during response");
endmodule

// *** sarseq_top.sv ***
// SAR converter sequencer: AXI4-Lite registers, trigger selection,
// channel scan, sample/convert timing and result storage.
// Assumes the analog core presents a settled result at the end of the
// last conversion cycle, on this clock.
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
// How it works
// - Conversion clock is peripheral clock over 2^(code+1); 0xf reserved.
// - First and last channel fields are 3 bits, both reset to zero.
// - First above last scans upward, wraps from seven to zero, ends at last.
// - One-time mode converts first to last once per trigger, then stops.
// - Continuous mode repeats the channel range until software stops it.
// - Trigger field: 0 software, 1 timer underflow, 3 external pin; resets 0.
// - External source starts a scan on a falling edge of the pin.
// - Timer source starts a scan on a timer underflow pulse while no scan runs.
// - Software source starts a scan on writing 1 to the active bit.
// - Sampling lasts code plus two conversion clocks; field resets to 7.
// - Each channel takes sampling plus 11 conversion clock cycles.
// - Result sits in upper or lower ten bits by justify bit; rest zero.
// - Triggers are taken only while the converter enable bit is 1.
// - Only the selected trigger source can start a scan.
// - A scan always begins sampling at the configured first channel.
// - Active bit reads 1 throughout any scan, whatever started it.
// - A readable 3-bit field shows the channel being converted.
// - Each channel end loads the result and sets ready; reading clears it.
// - Completion with ready still set overwrites and sets sticky overrun.
// - One-time scan clears active at end; continuous write 0 aborts.
// - One interrupt line from ready or overrun, each with its enable.
module sarseq_top (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [3:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic timer_underflow_i,
    input wire logic ext_trigger_pin_n_i,
    input wire logic [9:0] adc_result_i,
    output logic adc_clk_o,
    output logic [2:0] adc_channel_o,
    output logic adc_sample_o,
    output logic adc_convert_o,
    output logic irq_o
);
    // Bus slave state
    logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
    logic [3:0] aw_addr_q;
    logic [15:0] w_data_q;
    logic [1:0] w_strb_q, bresp_q, rresp_q;
    logic [15:0] rdata_q;
    // Settings
    logic [2:0] first_q, last_q, samp_q;
    logic [1:0] src_q;
    logic mode_q, just_q, en_q, rie_q, oie_q;
    logic [3:0] div_q;
    // Sequencer
    sarseq_pkg::sarseq_state_t state_q, state_d;
    logic [2:0] chan_q, chan_d;
    logic [3:0] cnt_q, cnt_d;
    logic [15:0] result_q;
    logic rdy_q, ovr_q;
    // External pin synchroniser
    logic ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q;

    sarseq_clk_if cif ();

    sarseq_clkdiv u_div (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .cif(cif)
    );

    // Register readback by address
    function automatic logic [15:0] reg_val(input logic [3:0] a);
        logic [15:0] v;
        v = 16'h0000;
        case (a)
            sarseq_pkg::ADDR_RESULT: v = result_q;
            sarseq_pkg::ADDR_TRIG: v = {just_q, samp_q, 1'b0, src_q,
                                        mode_q, 1'b0, last_q, 1'b0,
                                        first_q};
            sarseq_pkg::ADDR_CTL: v = {5'h00, chan_q, 2'h0, ovr_q, rdy_q,
                                       oie_q, rie_q,
                                       state_q != sarseq_pkg::SQ_IDLE,
                                       en_q};
            sarseq_pkg::ADDR_CLK: v = {12'h000, div_q};
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    function automatic logic mapped(input logic [3:0] a);
        return a == sarseq_pkg::ADDR_RESULT || a == sarseq_pkg::ADDR_TRIG ||
               a == sarseq_pkg::ADDR_CTL || a == sarseq_pkg::ADDR_CLK;
    endfunction

    // Write decode: byte lanes merge over the current register value
    logic [15:0] wr_cur, wr_val;
    logic wr_fire, lane0, wr_trig, wr_ctl, wr_clk;
    logic ar_fire, rd_result;
    assign wr_fire = aw_have_q && w_have_q;
    assign wr_cur = reg_val(aw_addr_q);
    assign wr_val = {w_strb_q[1] ? w_data_q[15:8] : wr_cur[15:8],
                     w_strb_q[0] ? w_data_q[7:0] : wr_cur[7:0]};
    assign lane0 = w_strb_q[0];
    assign wr_trig = wr_fire && aw_addr_q == sarseq_pkg::ADDR_TRIG;
    assign wr_ctl = wr_fire && aw_addr_q == sarseq_pkg::ADDR_CTL;
    assign wr_clk = wr_fire && aw_addr_q == sarseq_pkg::ADDR_CLK;
    assign ar_fire = s_axi_arvalid_i && !rvalid_q;
    assign rd_result = ar_fire && s_axi_araddr_i == sarseq_pkg::ADDR_RESULT;

    // Bus handshakes
    assign s_axi_awready_o = !aw_have_q && !bvalid_q;
    assign s_axi_wready_o = !w_have_q && !bvalid_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = !rvalid_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = {16'h0000, rdata_q};
    assign s_axi_rresp_o = rresp_q;

    // Write address and data latch in either order, then one response
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 16'h0000;
            w_strb_q <= 2'h0;
            bvalid_q <= 1'b0;
            bresp_q <= sarseq_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata_i[15:0];
                w_strb_q <= s_axi_wstrb_i[1:0];
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= mapped(aw_addr_q) ? sarseq_pkg::RESP_OKAY :
                           sarseq_pkg::RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready_i) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read channel: data registered one cycle after the address
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rvalid_q <= 1'b0;
            rdata_q <= 16'h0000;
            rresp_q <= sarseq_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= reg_val(s_axi_araddr_i);
            rresp_q <= mapped(s_axi_araddr_i) ? sarseq_pkg::RESP_OKAY :
                       sarseq_pkg::RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            rvalid_q <= 1'b0;
        end
    end

    // Settings registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            first_q <= sarseq_pkg::CHAN_RST;
            last_q <= sarseq_pkg::CHAN_RST;
            mode_q <= 1'b0;
            src_q <= sarseq_pkg::SRC_RST;
            samp_q <= sarseq_pkg::SAMP_RST;
            just_q <= 1'b0;
            div_q <= sarseq_pkg::DIV_RST;
            en_q <= 1'b0;
            rie_q <= 1'b0;
            oie_q <= 1'b0;
        end else begin
            if (wr_trig) begin
                first_q <= wr_val[sarseq_pkg::TRG_FIRST_LSB +: 3];
                last_q <= wr_val[sarseq_pkg::TRG_LAST_LSB +: 3];
                mode_q <= wr_val[sarseq_pkg::TRG_MODE_BIT];
                src_q <= wr_val[sarseq_pkg::TRG_SRC_LSB +: 2];
                samp_q <= wr_val[sarseq_pkg::TRG_SAMP_LSB +: 3];
                just_q <= wr_val[sarseq_pkg::TRG_JUST_BIT];
            end
            if (wr_ctl) begin
                en_q <= wr_val[sarseq_pkg::CTL_EN_BIT];
                rie_q <= wr_val[sarseq_pkg::CTL_RIE_BIT];
                oie_q <= wr_val[sarseq_pkg::CTL_OIE_BIT];
            end
            if (wr_clk) begin
                div_q <= wr_val[3:0];
            end
        end
    end

    // Pin passes three flops; a change counts once stages two and three agree
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ext_s1_q <= 1'b1;
            ext_s2_q <= 1'b1;
            ext_s3_q <= 1'b1;
            ext_lvl_q <= 1'b1;
        end else begin
            ext_s1_q <= ext_trigger_pin_n_i;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            if (ext_s2_q == ext_s3_q) begin
                ext_lvl_q <= ext_s3_q;
            end
        end
    end

    // Trigger selection and acceptance
    logic ext_fall, sw_start, trig_hit, start, busy, abort;
    assign ext_fall = ext_lvl_q && ext_s2_q == ext_s3_q && !ext_s3_q;
    assign sw_start = wr_ctl && lane0 && wr_val[sarseq_pkg::CTL_ACT_BIT];
    assign trig_hit = (src_q == sarseq_pkg::SRC_SOFT && sw_start) ||
                      (src_q == sarseq_pkg::SRC_TIMER &&
                       timer_underflow_i) ||
                      (src_q == sarseq_pkg::SRC_EXT && ext_fall);
    assign busy = state_q != sarseq_pkg::SQ_IDLE;
    assign start = en_q && !busy && trig_hit;
    assign abort = busy && (!en_q || (mode_q && wr_ctl && lane0 &&
                   !wr_val[sarseq_pkg::CTL_ACT_BIT]));

    // Phase timing in conversion clock ticks
    logic samp_last, conv_last, done;
    assign samp_last = cnt_q == {1'b0, samp_q} + sarseq_pkg::SAMP_LAST_OFS;
    assign conv_last = cnt_q == sarseq_pkg::CONV_LAST;
    assign done = state_q == sarseq_pkg::SQ_CONVERT && cif.tick && conv_last;
    assign cif.div_sel = div_q;
    assign cif.restart = start;

    // Scan state machine
    always_comb begin
        state_d = state_q;
        chan_d = chan_q;
        cnt_d = cnt_q;
        if (abort) begin
            state_d = sarseq_pkg::SQ_IDLE;
            cnt_d = 4'h0;
        end else begin
            case (state_q)
                sarseq_pkg::SQ_IDLE: begin
                    if (start) begin
                        state_d = sarseq_pkg::SQ_SAMPLE;
                        chan_d = first_q;
                        cnt_d = 4'h0;
                    end
                end
                sarseq_pkg::SQ_SAMPLE: begin
                    if (cif.tick) begin
                        if (samp_last) begin
                            state_d = sarseq_pkg::SQ_CONVERT;
                            cnt_d = 4'h0;
                        end else begin
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                sarseq_pkg::SQ_CONVERT: begin
                    if (cif.tick) begin
                        if (conv_last) begin
                            cnt_d = 4'h0;
                            state_d = sarseq_pkg::SQ_SAMPLE;
                            if (chan_q != last_q) begin
                                chan_d = chan_q + 3'h1;
                            end else if (mode_q) begin
                                chan_d = first_q;
                            end else begin
                                state_d = sarseq_pkg::SQ_IDLE;
                            end
                        end else begin
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                default: state_d = sarseq_pkg::SQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= sarseq_pkg::SQ_IDLE;
            chan_q <= sarseq_pkg::CHAN_RST;
            cnt_q <= 4'h0;
        end else begin
            state_q <= state_d;
            chan_q <= chan_d;
            cnt_q <= cnt_d;
        end
    end

    // Result store and flags; a completion wins over a same-cycle clear
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_q <= 16'h0000;
            rdy_q <= 1'b0;
            ovr_q <= 1'b0;
        end else begin
            if (done) begin
                result_q <= just_q ? {adc_result_i, 6'h00} :
                            {6'h00, adc_result_i};
                rdy_q <= 1'b1;
            end else if (rd_result) begin
                rdy_q <= 1'b0;
            end
            if (done && rdy_q) begin
                ovr_q <= 1'b1;
            end else if (wr_ctl && lane0 &&
                         wr_val[sarseq_pkg::CTL_OVR_BIT]) begin
                ovr_q <= 1'b0;
            end
        end
    end

    // Core and interrupt outputs
    assign adc_clk_o = cif.level;
    assign adc_channel_o = chan_q;
    assign adc_sample_o = state_q == sarseq_pkg::SQ_SAMPLE;
    assign adc_convert_o = state_q == sarseq_pkg::SQ_CONVERT;
    assign irq_o = (rdy_q && rie_q) || (ovr_q && oie_q);
endmodule
